// ### rtc_pkg.sv
// constants, register indices and state records of the tick/alarm clock
// assumes a 25 MHz system clock taken from the crystal oscillator
package rtc_pkg;

   // ***************
   // timing
   // ***************
   localparam int CLK_MHZ = 25;
   localparam int PRE_DIV = 64;
   localparam logic [5:0] PRE_LAST = 6'(PRE_DIV - 1);

   // ***************
   // register indices, byte address is four times the index
   // ***************
   localparam int ADDR_W = 8;
   localparam logic [5:0] IDX_CTRL = 6'h00;
   localparam logic [5:0] IDX_PRE_LO = 6'h06;
   localparam logic [5:0] IDX_PRE_HI = 6'h08;
   localparam logic [5:0] IDX_DIV_LO = 6'h0A;
   localparam logic [5:0] IDX_DIV_HI = 6'h0C;
   localparam logic [5:0] IDX_CNT_LO = 6'h10;
   localparam logic [5:0] IDX_CNT_HI = 6'h12;
   localparam logic [5:0] IDX_ALM_LO = 6'h14;
   localparam logic [5:0] IDX_ALM_HI = 6'h16;
   localparam logic [5:0] IDX_ROUTE = 6'h18;

   // ***************
   // field positions
   // ***************
   localparam int CTL_TICK_REQ = 0;
   localparam int CTL_TICK_EN = 1;
   localparam int CTL_ALM_REQ = 2;
   localparam int CTL_ALM_EN = 3;
   localparam int CTL_OSC_OFF = 7;
   localparam int RT_TICK = 0;
   localparam int RT_ALM = 1;
   localparam int RT_WAKE = 2;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ***************
   // state records
   // ***************
   typedef struct packed {
      logic [5:0] pre;
      logic [19:0] div;
      logic tick;
   } rtc_chain_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic aw_got;
      logic w_got;
      logic [5:0] waddr;
      logic [15:0] wdata;
      logic [1:0] wstrb;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic osc_off;
      logic alarm_en;
      logic alarm_req;
      logic tick_en;
      logic tick_req;
      logic [19:0] prescale;
      logic [31:0] count;
      logic [31:0] alarm;
      logic [2:0] route;
      logic [1:0] pd_sync;
      logic tick_irq;
      logic alarm_irq;
      logic [1:0] ext_irq;
      logic osc_stop;
      logic wake;
   } rtc_state_t;

   localparam rtc_chain_t CHAIN_RESET = '0;
   localparam rtc_state_t STATE_RESET = '0;

endpackage

// ### rtc_tick_chain.sv
// fixed 1/64 pre-divider followed by the 20-bit reloadable divider
// assumes run, load and prescale come from logic on the same clock
`timescale 1ns/1ns
module rtc_tick_chain
(
   // clock and backup-domain reset
   input wire logic clk_in,
   input wire logic rst_in,
   // control
   input wire logic run_in,
   input wire logic load_in,
   input wire logic [19:0] prescale_in,
   // results
   output logic tick_out,
   output logic [19:0] divider_out
);

   rtc_pkg::rtc_chain_t s;
   rtc_pkg::rtc_chain_t next_s;
   logic pre_pulse;

   // ***************
   // counting
   // ***************
   always_comb
   begin
      next_s = s;
      next_s.tick = 1'b0;
      pre_pulse = run_in && (s.pre == rtc_pkg::PRE_LAST);
      if (run_in)
      begin
         next_s.pre = s.pre + 6'h01;
      end
      // a new prescale value takes effect at once, not after the old period
      if (load_in)
      begin
         next_s.div = prescale_in;
      end
      else if (pre_pulse)
      begin
         if (s.div == 20'h00000)
         begin
            next_s.div = prescale_in;
            next_s.tick = 1'b1;
         end
         else
         begin
            next_s.div = s.div - 20'h00001;
         end
      end
      if (rst_in)
      begin
         next_s = rtc_pkg::CHAIN_RESET;
      end
   end

   always_ff @(posedge clk_in)
   begin
      s <= next_s;
   end

   assign tick_out = s.tick;
   assign divider_out = s.div;

   // ***************
   // checks
   // ***************
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);

   AST_PRE_SPACING: assert property (pre_pulse && run_in |=> !pre_pulse [*8])
      else $error("pre-divider pulses closer than expected");
   AST_DIV_RELOAD: assert property (pre_pulse && !load_in && s.div == 20'h00000
      |=> s.tick && s.div == $past(prescale_in))
      else $error("divider did not reload at zero");
   AST_DIV_STOP: assert property (!run_in && !load_in |=> $stable(s.div) && !s.tick)
      else $error("divider moved while stopped");

endmodule

// ### rtc_tick_alarm_counter.sv
// tick/alarm real-time clock with an AXI4-Lite register slave
// assumes CLOCK_IN is the crystal clock; POWERDOWN_IN arrives asynchronously
//
// The AXI4-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ns

module rtc_tick_alarm_counter
(
   // clock and resets
   input wire logic CLOCK_IN,
   input wire logic SYS_RST_IN,
   input wire logic PWR_ON_RST_IN,
   // chip power state
   input wire logic POWERDOWN_IN,
   // axi write address and data
   input wire logic [7:0] S_AXI_AWADDR_IN,
   input wire logic S_AXI_AWVALID_IN,
   output logic S_AXI_AWREADY_OUT,
   input wire logic [31:0] S_AXI_WDATA_IN,
   input wire logic [3:0] S_AXI_WSTRB_IN,
   input wire logic S_AXI_WVALID_IN,
   output logic S_AXI_WREADY_OUT,
   // axi write response
   output logic [1:0] S_AXI_BRESP_OUT,
   output logic S_AXI_BVALID_OUT,
   input wire logic S_AXI_BREADY_IN,
   // axi read
   input wire logic [7:0] S_AXI_ARADDR_IN,
   input wire logic S_AXI_ARVALID_IN,
   output logic S_AXI_ARREADY_OUT,
   output logic [31:0] S_AXI_RDATA_OUT,
   output logic [1:0] S_AXI_RRESP_OUT,
   output logic S_AXI_RVALID_OUT,
   input wire logic S_AXI_RREADY_IN,
   // requests and power control
   output logic TICK_IRQ_OUT,
   output logic ALARM_IRQ_OUT,
   output logic [1:0] EXT_IRQ_OUT,
   output logic OSC_STOP_OUT,
   output logic WAKE_OUT
);

   rtc_pkg::rtc_state_t s;
   rtc_pkg::rtc_state_t next_s;
   logic tick_ev;
   logic alarm_ev;
   logic wr_go;
   logic pre_load;
   logic pd;
   logic [19:0] divider;
   logic [31:0] count_inc;
   logic [31:0] rd;
   logic [1:0] rd_resp;

   function automatic logic [15:0] lane16(input logic [15:0] old, input logic [15:0] d,
                                          input logic [1:0] st);
      lane16 = {st[1] ? d[15:8] : old[15:8], st[0] ? d[7:0] : old[7:0]};
   endfunction

   // ***************
   // tick source
   // ***************
   // 6 + 20 + 32 stages give the 58-bit long-term timer
   rtc_tick_chain u_chain
   (
      .clk_in(CLOCK_IN),
      .rst_in(PWR_ON_RST_IN),
      .run_in(!s.osc_off),
      .load_in(pre_load),
      .prescale_in(next_s.prescale),
      .tick_out(tick_ev),
      .divider_out(divider)
   );

   assign pd = s.pd_sync[1];
   assign count_inc = s.count + 32'h00000001;

   // ***************
   // read decode
   // ***************
   always_comb
   begin
      rd = 32'h00000000;
      rd_resp = rtc_pkg::RESP_OKAY;
      case (S_AXI_ARADDR_IN[7:2])
         rtc_pkg::IDX_CTRL:
         begin
            rd[rtc_pkg::CTL_OSC_OFF] = s.osc_off;
            rd[rtc_pkg::CTL_ALM_EN] = s.alarm_en;
            rd[rtc_pkg::CTL_ALM_REQ] = s.alarm_req;
            rd[rtc_pkg::CTL_TICK_EN] = s.tick_en;
            rd[rtc_pkg::CTL_TICK_REQ] = s.tick_req;
         end
         rtc_pkg::IDX_PRE_LO: rd[15:0] = s.prescale[15:0];
         rtc_pkg::IDX_PRE_HI: rd[3:0] = s.prescale[19:16];
         rtc_pkg::IDX_DIV_LO: rd[15:0] = divider[15:0];
         rtc_pkg::IDX_DIV_HI: rd[3:0] = divider[19:16];
         rtc_pkg::IDX_CNT_LO: rd[15:0] = s.count[15:0];
         rtc_pkg::IDX_CNT_HI: rd[15:0] = s.count[31:16];
         rtc_pkg::IDX_ALM_LO: rd[15:0] = s.alarm[15:0];
         rtc_pkg::IDX_ALM_HI: rd[15:0] = s.alarm[31:16];
         rtc_pkg::IDX_ROUTE: rd[2:0] = s.route;
         default: rd_resp = rtc_pkg::RESP_SLVERR;
      endcase
   end

   // ***************
   // next state
   // ***************
   always_comb
   begin
      next_s = s;
      pre_load = 1'b0;
      next_s.pd_sync = {s.pd_sync[0], POWERDOWN_IN};

      // write address and data, taken in either order
      if (S_AXI_AWVALID_IN && s.awready)
      begin
         next_s.aw_got = 1'b1;
         next_s.waddr = S_AXI_AWADDR_IN[7:2];
      end
      if (S_AXI_WVALID_IN && s.wready)
      begin
         next_s.w_got = 1'b1;
         next_s.wdata = S_AXI_WDATA_IN[15:0];
         next_s.wstrb = S_AXI_WSTRB_IN[1:0];
      end
      if (s.bvalid && S_AXI_BREADY_IN)
      begin
         next_s.bvalid = 1'b0;
      end
      wr_go = next_s.aw_got && next_s.w_got && !s.bvalid;

      if (wr_go)
      begin
         next_s.aw_got = 1'b0;
         next_s.w_got = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = rtc_pkg::RESP_OKAY;
         case (next_s.waddr)
            rtc_pkg::IDX_CTRL:
            begin
               if (next_s.wstrb[0])
               begin
                  next_s.osc_off = next_s.wdata[rtc_pkg::CTL_OSC_OFF];
                  next_s.alarm_en = next_s.wdata[rtc_pkg::CTL_ALM_EN];
                  next_s.alarm_req = next_s.wdata[rtc_pkg::CTL_ALM_REQ];
                  next_s.tick_en = next_s.wdata[rtc_pkg::CTL_TICK_EN];
                  next_s.tick_req = next_s.wdata[rtc_pkg::CTL_TICK_REQ];
               end
            end
            // prescale and counters are guarded by the switch-off bit
            rtc_pkg::IDX_PRE_LO:
            begin
               if (s.osc_off)
               begin
                  next_s.prescale[15:0] = lane16(s.prescale[15:0], next_s.wdata,
                                                 next_s.wstrb);
                  pre_load = 1'b1;
               end
            end
            rtc_pkg::IDX_PRE_HI:
            begin
               if (s.osc_off && next_s.wstrb[0])
               begin
                  next_s.prescale[19:16] = next_s.wdata[3:0];
                  pre_load = 1'b1;
               end
            end
            rtc_pkg::IDX_CNT_LO:
            begin
               if (s.osc_off)
               begin
                  next_s.count[15:0] = lane16(s.count[15:0], next_s.wdata, next_s.wstrb);
               end
            end
            rtc_pkg::IDX_CNT_HI:
            begin
               if (s.osc_off)
               begin
                  next_s.count[31:16] = lane16(s.count[31:16], next_s.wdata, next_s.wstrb);
               end
            end
            rtc_pkg::IDX_ALM_LO:
               next_s.alarm[15:0] = lane16(s.alarm[15:0], next_s.wdata, next_s.wstrb);
            rtc_pkg::IDX_ALM_HI:
               next_s.alarm[31:16] = lane16(s.alarm[31:16], next_s.wdata, next_s.wstrb);
            rtc_pkg::IDX_ROUTE:
            begin
               if (next_s.wstrb[0])
               begin
                  next_s.route = next_s.wdata[2:0];
               end
            end
            // divider halves are read only; writes are dropped quietly
            rtc_pkg::IDX_DIV_LO, rtc_pkg::IDX_DIV_HI: next_s.bresp = rtc_pkg::RESP_OKAY;
            default: next_s.bresp = rtc_pkg::RESP_SLVERR;
         endcase
      end
      next_s.awready = !next_s.aw_got && !next_s.bvalid;
      next_s.wready = !next_s.w_got && !next_s.bvalid;

      // read channel, one outstanding
      if (S_AXI_ARVALID_IN && s.arready)
      begin
         next_s.rvalid = 1'b1;
         next_s.rdata = rd;
         next_s.rresp = rd_resp;
      end
      else if (s.rvalid && S_AXI_RREADY_IN)
      begin
         next_s.rvalid = 1'b0;
      end
      next_s.arready = !next_s.rvalid;

      // time counter and events; an event beats a clear in the same cycle
      if (tick_ev)
      begin
         next_s.count = count_inc;
         next_s.tick_req = 1'b1;
         if (count_inc == s.alarm)
         begin
            next_s.alarm_req = 1'b1;
         end
      end
      alarm_ev = tick_ev && (count_inc == s.alarm);

      // gated requests and power-down control
      next_s.tick_irq = next_s.tick_req && next_s.tick_en;
      next_s.alarm_irq = next_s.alarm_req && next_s.alarm_en;
      next_s.ext_irq[0] = next_s.tick_irq && next_s.route[rtc_pkg::RT_TICK];
      next_s.ext_irq[1] = next_s.alarm_irq && next_s.route[rtc_pkg::RT_ALM];
      next_s.osc_stop = next_s.osc_off && pd;
      next_s.wake = pd && next_s.route[rtc_pkg::RT_WAKE] && (|next_s.ext_irq);

      // system reset touches only the bus side
      if (SYS_RST_IN)
      begin
         next_s.awready = 1'b0;
         next_s.wready = 1'b0;
         next_s.bvalid = 1'b0;
         next_s.bresp = rtc_pkg::RESP_OKAY;
         next_s.aw_got = 1'b0;
         next_s.w_got = 1'b0;
         next_s.arready = 1'b0;
         next_s.rvalid = 1'b0;
         next_s.rresp = rtc_pkg::RESP_OKAY;
      end
      if (PWR_ON_RST_IN)
      begin
         next_s = rtc_pkg::STATE_RESET;
      end
   end

   always_ff @(posedge CLOCK_IN)
   begin
      s <= next_s;
   end

   // ***************
   // outputs
   // ***************
   assign S_AXI_AWREADY_OUT = s.awready;
   assign S_AXI_WREADY_OUT = s.wready;
   assign S_AXI_BRESP_OUT = s.bresp;
   assign S_AXI_BVALID_OUT = s.bvalid;
   assign S_AXI_ARREADY_OUT = s.arready;
   assign S_AXI_RDATA_OUT = s.rdata;
   assign S_AXI_RRESP_OUT = s.rresp;
   assign S_AXI_RVALID_OUT = s.rvalid;
   assign TICK_IRQ_OUT = s.tick_irq;
   assign ALARM_IRQ_OUT = s.alarm_irq;
   assign EXT_IRQ_OUT = s.ext_irq;
   assign OSC_STOP_OUT = s.osc_stop;
   assign WAKE_OUT = s.wake;

   // ***************
   // checks
   // ***************
   default clocking @(posedge CLOCK_IN); endclocking
   default disable iff (PWR_ON_RST_IN || SYS_RST_IN);

   sequence seq_tick;
      tick_ev;
   endsequence
   sequence seq_match;
      seq_tick ##0 (count_inc == s.alarm);
   endsequence
   sequence seq_locked_cnt_write;
      wr_go && !s.osc_off && !tick_ev &&
         (next_s.waddr == rtc_pkg::IDX_CNT_LO || next_s.waddr == rtc_pkg::IDX_CNT_HI);
   endsequence

   AST_TICK_FLAG: assert property (seq_tick |=> s.tick_req && (s.tick_irq == s.tick_en))
      else $error("tick did not set its request");
   AST_COUNT_STEP: assert property (seq_tick |=> s.count == $past(s.count) + 32'h00000001)
      else $error("time counter did not advance by one");
   AST_ALARM_MATCH: assert property (seq_match |=> s.alarm_req)
      else $error("alarm match missed");
   AST_ALARM_CAUSE: assert property ($rose(s.alarm_req) |-> $past(alarm_ev) ||
      $past(wr_go && next_s.waddr == rtc_pkg::IDX_CTRL))
      else $error("alarm request without a matching tick");
   AST_LOCKED: assert property (seq_locked_cnt_write |=> $stable(s.count))
      else $error("protected counter written while running");
   AST_OSC_STOP: assert property (s.osc_off && pd |=> OSC_STOP_OUT == s.osc_off)
      else $error("oscillator not stopped in power down");
   AST_WAKE_GATE: assert property (WAKE_OUT |-> s.route[rtc_pkg::RT_WAKE] && $past(pd))
      else $error("wake without wake configuration");
   AST_IRQ_GATE: assert property (TICK_IRQ_OUT |-> $past(next_s.tick_en))
      else $error("tick request passed while disabled");
   AST_BRESP: assert property (wr_go |=> S_AXI_BVALID_OUT && !S_AXI_AWREADY_OUT)
      else $error("write not answered");
   // own disable: the default one would switch this check off whenever it applies
   AST_SYS_KEEP: assert property (disable iff (PWR_ON_RST_IN)
      SYS_RST_IN && !tick_ev && !wr_go |=> $stable(s.count))
      else $error("system reset disturbed the counter");

endmodule

// ### rtc_axi_host.sv
// processor-side model: AXI4-Lite master issuing one register access at a time
// assumes callers enter its tasks just after a rising clock edge
`timescale 1ns/1ns
module rtc_axi_host
(
   // clock
   input wire logic clk_in,
   // write channels
   output logic [7:0] awaddr_out,
   output logic awvalid_out,
   input wire logic awready_in,
   output logic [31:0] wdata_out,
   output logic [3:0] wstrb_out,
   output logic wvalid_out,
   input wire logic wready_in,
   input wire logic [1:0] bresp_in,
   input wire logic bvalid_in,
   output logic bready_out,
   // read channels
   output logic [7:0] araddr_out,
   output logic arvalid_out,
   input wire logic arready_in,
   input wire logic [31:0] rdata_in,
   input wire logic [1:0] rresp_in,
   input wire logic rvalid_in,
   output logic rready_out
);
   initial
   begin
      {awvalid_out, wvalid_out, bready_out, arvalid_out, rready_out} = 5'h00;
      {awaddr_out, araddr_out} = 16'h0000;
      wdata_out = 32'h00000000;
      wstrb_out = 4'h0;
   end

   // released payloads are inverted so nothing leans on stale values
   task automatic bus_write(input logic [7:0] addr, input logic [31:0] data,
                            output logic [1:0] resp);
      logic aw_done;
      logic w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      awaddr_out <= addr;
      wdata_out <= data;
      wstrb_out <= 4'hF;
      awvalid_out <= 1'b1;
      wvalid_out <= 1'b1;
      while (!(aw_done && w_done))
      begin
         @(posedge clk_in);
         if (!aw_done && awready_in)
         begin
            aw_done = 1'b1;
            awvalid_out <= 1'b0;
            awaddr_out <= ~addr;
         end
         if (!w_done && wready_in)
         begin
            w_done = 1'b1;
            wvalid_out <= 1'b0;
            wdata_out <= ~data;
         end
      end
      bready_out <= 1'b1;
      do
         @(posedge clk_in);
      while (!bvalid_in);
      resp = bresp_in;
      bready_out <= 1'b0;
   endtask

   task automatic bus_read(input logic [7:0] addr, output logic [31:0] data,
                           output logic [1:0] resp);
      araddr_out <= addr;
      arvalid_out <= 1'b1;
      do
         @(posedge clk_in);
      while (!arready_in);
      arvalid_out <= 1'b0;
      araddr_out <= ~addr;
      rready_out <= 1'b1;
      do
         @(posedge clk_in);
      while (!rvalid_in);
      data = rdata_in;
      resp = rresp_in;
      rready_out <= 1'b0;
   endtask
endmodule

// ### tb_top.sv
// self-checking bench for the tick/alarm clock, driven through the bus model
// assumes the package register indices and a 25 MHz clock
`timescale 1ns/1ns
module tb_top;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic por_rst = 1'b1;
   logic pwr_down = 1'b0;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd_val, frozen;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, resp, ext_irq;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic tick_irq, alarm_irq, osc_stop, wake;
   logic tick_q = 1'b0;
   int miscompares = 0;
   int checked = 0;
   int cyc = 0;
   int rise_cyc = 0;
   int t1;

   always #20 clk = ~clk;

   rtc_axi_host u_host (.clk_in(clk), .awaddr_out(awaddr), .awvalid_out(awvalid),
      .awready_in(awready), .wdata_out(wdata), .wstrb_out(wstrb), .wvalid_out(wvalid),
      .wready_in(wready), .bresp_in(bresp), .bvalid_in(bvalid), .bready_out(bready),
      .araddr_out(araddr), .arvalid_out(arvalid), .arready_in(arready),
      .rdata_in(rdata), .rresp_in(rresp), .rvalid_in(rvalid), .rready_out(rready));

   rtc_tick_alarm_counter u_dut (.CLOCK_IN(clk), .SYS_RST_IN(sys_rst),
      .PWR_ON_RST_IN(por_rst), .POWERDOWN_IN(pwr_down), .S_AXI_AWADDR_IN(awaddr),
      .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready), .S_AXI_WDATA_IN(wdata),
      .S_AXI_WSTRB_IN(wstrb), .S_AXI_WVALID_IN(wvalid), .S_AXI_WREADY_OUT(wready),
      .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready),
      .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid), .S_AXI_ARREADY_OUT(arready),
      .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid),
      .S_AXI_RREADY_IN(rready), .TICK_IRQ_OUT(tick_irq), .ALARM_IRQ_OUT(alarm_irq),
      .EXT_IRQ_OUT(ext_irq), .OSC_STOP_OUT(osc_stop), .WAKE_OUT(wake));

   // tick edges are timestamped so the period is measured, not assumed
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      tick_q <= tick_irq;
      if (tick_irq && !tick_q)
         rise_cyc <= cyc;
   end

   // ***************
   // helpers
   // ***************
   task automatic test_done;
      $display("checks %0d, mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [5:0] idx, input logic [15:0] data, input logic [1:0] er);
      u_host.bus_write({idx, 2'b00}, {16'h0000, data}, resp);
      chk({30'h0, resp}, {30'h0, er});
   endtask

   task automatic rd(input logic [5:0] idx, input logic [31:0] exp);
      u_host.bus_read({idx, 2'b00}, rd_val, resp);
      chk(rd_val, exp);
   endtask

   // bounded wait for the next rising tick request
   task automatic wait_tick(input int limit);
      int start;
      int n;
      start = rise_cyc;
      n = 0;
      while (rise_cyc == start && n < limit)
      begin
         @(posedge clk);
         n++;
      end
      chk({31'h0, n >= limit}, 32'h0);
   endtask

   // ***************
   // tests
   // ***************
   initial
   begin
      repeat (10) @(posedge clk);
      por_rst <= 1'b0;
      sys_rst <= 1'b0;
      @(posedge clk);
      chk({27'h0, tick_irq, alarm_irq, ext_irq, osc_stop}, 32'h0);
      @(posedge clk);
      rd(rtc_pkg::IDX_CTRL, 32'h0);
      u_host.bus_read(8'h04, rd_val, resp);
      chk({30'h0, resp}, {30'h0, rtc_pkg::RESP_SLVERR});
      wr(6'h01, 16'hFFFF, rtc_pkg::RESP_SLVERR);
      wr(rtc_pkg::IDX_CTRL, 16'h0080, rtc_pkg::RESP_OKAY);
      wr(rtc_pkg::IDX_PRE_LO, 16'h0003, rtc_pkg::RESP_OKAY);
      wr(rtc_pkg::IDX_PRE_HI, 16'h0000, rtc_pkg::RESP_OKAY);
      rd(rtc_pkg::IDX_DIV_LO, 32'h3);
      wr(rtc_pkg::IDX_DIV_LO, 16'h0001, rtc_pkg::RESP_OKAY);
      rd(rtc_pkg::IDX_DIV_LO, 32'h3);
      rd(rtc_pkg::IDX_DIV_HI, 32'h0);
      wr(rtc_pkg::IDX_CNT_LO, 16'hFFFE, rtc_pkg::RESP_OKAY);
      wr(rtc_pkg::IDX_CNT_HI, 16'hFFFF, rtc_pkg::RESP_OKAY);
      wr(rtc_pkg::IDX_ALM_LO, 16'h0000, rtc_pkg::RESP_OKAY);
      wr(rtc_pkg::IDX_ALM_HI, 16'h0000, rtc_pkg::RESP_OKAY);
      repeat (300) @(posedge clk);
      rd(rtc_pkg::IDX_CNT_LO, 32'hFFFE);
      rd(rtc_pkg::IDX_CNT_HI, 32'hFFFF);
      wr(rtc_pkg::IDX_ROUTE, 16'h0007, rtc_pkg::RESP_OKAY);
      wr(rtc_pkg::IDX_CTRL, 16'h000A, rtc_pkg::RESP_OKAY);
      wait_tick(400);
      t1 = rise_cyc;
      chk({30'h0, alarm_irq, ext_irq[0]}, 32'h1);
      rd(rtc_pkg::IDX_CNT_LO, 32'hFFFF);
      wr(rtc_pkg::IDX_CTRL, 16'h000A, rtc_pkg::RESP_OKAY);
      @(posedge clk);
      chk({31'h0, tick_irq}, 32'h0);
      wait_tick(300);
      chk(rise_cyc - t1, 32'd256);
      chk({29'h0, alarm_irq, ext_irq}, 32'h7);
      rd(rtc_pkg::IDX_CNT_LO, 32'h0);
      rd(rtc_pkg::IDX_CNT_HI, 32'h0);
      pwr_down <= 1'b1;
      repeat (5) @(posedge clk);
      chk({30'h0, wake, osc_stop}, 32'h2);
      pwr_down <= 1'b0;
      // the counter still equals the alarm here, so a re-raise would show
      wr(rtc_pkg::IDX_CTRL, 16'h000A, rtc_pkg::RESP_OKAY);
      repeat (20) @(posedge clk);
      chk({31'h0, alarm_irq}, 32'h0);
      wr(rtc_pkg::IDX_CTRL, 16'h0004, rtc_pkg::RESP_OKAY);
      repeat (2) @(posedge clk);
      chk({31'h0, alarm_irq}, 32'h0);
      wr(rtc_pkg::IDX_CTRL, 16'h000C, rtc_pkg::RESP_OKAY);
      repeat (2) @(posedge clk);
      chk({31'h0, alarm_irq}, 32'h1);
      wr(rtc_pkg::IDX_CNT_HI, 16'h1234, rtc_pkg::RESP_OKAY);
      rd(rtc_pkg::IDX_CNT_HI, 32'h0);
      wr(rtc_pkg::IDX_CTRL, 16'h0080, rtc_pkg::RESP_OKAY);
      rd(rtc_pkg::IDX_CNT_LO, 32'h0);
      frozen = rd_val;
      repeat (300) @(posedge clk);
      rd(rtc_pkg::IDX_CNT_LO, frozen);
      pwr_down <= 1'b1;
      repeat (5) @(posedge clk);
      chk({30'h0, wake, osc_stop}, 32'h1);
      sys_rst <= 1'b1;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (2) @(posedge clk);
      rd(rtc_pkg::IDX_CNT_LO, frozen);
      rd(rtc_pkg::IDX_PRE_LO, 32'h3);
      test_done();
   end

   // whole run is near 1200 cycles; sixteen times that means a hang
   initial
   begin
      repeat (20000) @(posedge clk);
      miscompares++;
      test_done();
   end
endmodule
